// File: mst_skip_table_xor.sv
// execution stage for skip, nibble swap, table read and exclusive-or instructions
`timescale 1ns/1ps
module mst_skip_table_xor
  import mst_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic op_valid_in,
  input wire mst_op_t op_in,
  input wire logic [ADDR_W-1:0] mem_addr_in,
  input wire logic [DATA_W-1:0] mem_byte_in,
  input wire logic [DATA_W-1:0] acc_in,
  input wire logic [DATA_W-1:0] imm_in,
  input wire logic [2:0] bit_sel_in,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic [TP_W-1:0] table_pointer_in,
  input wire logic [ROM_W-1:0] prog_data_in,
  output logic ready_out,
  output logic skip_out,
  output logic acc_we_out,
  output logic [DATA_W-1:0] acc_out,
  output logic mem_we_out,
  output logic [ADDR_W-1:0] mem_addr_out,
  output logic [DATA_W-1:0] mem_wdata_out,
  output logic zero_we_out,
  output logic zero_flag_out,
  output logic prog_rd_out,
  output logic [PC_W-1:0] prog_addr_out,
  output logic table_high_we_out,
  output logic [HIGH_W-1:0] table_high_byte_reg_out
);

  // ==========================================
  // datapath
  logic take;
  logic ex_acc_we;
  logic [DATA_W-1:0] ex_acc;
  logic ex_mem_we;
  logic [DATA_W-1:0] ex_mem;
  logic ex_zero_we;
  logic ex_zero;
  logic ex_skip;
  logic ex_table;
  logic ex_last;

  assign take = op_valid_in & ready_out;

  mst_exec_unit u_exec (
    .op_in(op_in),
    .acc_in(acc_in),
    .mem_byte_in(mem_byte_in),
    .imm_in(imm_in),
    .bit_sel_in(bit_sel_in),
    .acc_we_out(ex_acc_we),
    .acc_out(ex_acc),
    .mem_we_out(ex_mem_we),
    .mem_out(ex_mem),
    .zero_we_out(ex_zero_we),
    .zero_out(ex_zero),
    .skip_out(ex_skip),
    .table_out(ex_table),
    .last_page_out(ex_last)
  );

  // ==========================================
  // sequencer and output registers
  mst_state_t state;
  mst_state_t next_state;
  logic next_ready;
  logic next_skip;
  logic next_acc_we;
  logic [DATA_W-1:0] next_acc;
  logic next_mem_we;
  logic [ADDR_W-1:0] next_mem_addr;
  logic [DATA_W-1:0] next_mem_wdata;
  logic next_zero_we;
  logic next_zero;
  logic next_prog_rd;
  logic [PC_W-1:0] next_prog_addr;
  logic next_high_we;
  logic [HIGH_W-1:0] next_high;

  always_comb
  begin
    next_state = state;
    next_ready = ready_out;
    next_skip = 1'b0;
    next_acc_we = 1'b0;
    next_acc = acc_out;
    next_mem_we = 1'b0;
    next_mem_addr = mem_addr_out;
    next_mem_wdata = mem_wdata_out;
    next_zero_we = 1'b0;
    next_zero = zero_flag_out;
    next_prog_rd = 1'b0;
    next_prog_addr = prog_addr_out;
    next_high_we = 1'b0;
    next_high = table_high_byte_reg_out;
    case (state)
      ST_IDLE:
      begin
        if (take)
        begin
          next_acc_we = ex_acc_we;
          next_acc = ex_acc;
          next_mem_we = ex_mem_we;
          next_mem_addr = mem_addr_in;
          next_mem_wdata = ex_mem;
          next_zero_we = ex_zero_we;
          if (ex_zero_we)
          begin
            next_zero = ex_zero;
          end
          if (ex_skip)
          begin
            next_skip = 1'b1;
            next_ready = 1'b0;
            next_state = ST_DUMMY;
          end
          else if (ex_table)
          begin
            next_prog_rd = 1'b1;
            next_ready = 1'b0;
            next_state = ST_TAB_ADDR;
            if (ex_last)
            begin
              next_prog_addr = {LAST_PAGE, table_pointer_in};
            end
            else
            begin
              next_prog_addr = {pc_in[PC_W-1:TP_W], table_pointer_in};
            end
          end
        end
      end
      ST_DUMMY:
      begin
        next_ready = 1'b1;
        next_state = ST_IDLE;
      end
      ST_TAB_ADDR:
      begin
        next_state = ST_TAB_DATA;
      end
      ST_TAB_DATA:
      begin
        next_mem_we = 1'b1;
        next_mem_wdata = prog_data_in[DATA_W-1:0];
        next_high_we = 1'b1;
        next_high = prog_data_in[ROM_W-1:DATA_W];
        next_ready = 1'b1;
        next_state = ST_IDLE;
      end
      default:
      begin
        next_ready = 1'b1;
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state <= ST_IDLE;
      ready_out <= 1'b1;
      skip_out <= 1'b0;
      acc_we_out <= 1'b0;
      acc_out <= ACC_RESET;
      mem_we_out <= 1'b0;
      mem_addr_out <= ADDR_RESET;
      mem_wdata_out <= BYTE_ZERO;
      zero_we_out <= 1'b0;
      zero_flag_out <= 1'b0;
      prog_rd_out <= 1'b0;
      prog_addr_out <= PROG_ADDR_RESET;
      table_high_we_out <= 1'b0;
      table_high_byte_reg_out <= HIGH_RESET;
    end
    else
    begin
      state <= next_state;
      ready_out <= next_ready;
      skip_out <= next_skip;
      acc_we_out <= next_acc_we;
      acc_out <= next_acc;
      mem_we_out <= next_mem_we;
      mem_addr_out <= next_mem_addr;
      mem_wdata_out <= next_mem_wdata;
      zero_we_out <= next_zero_we;
      zero_flag_out <= next_zero;
      prog_rd_out <= next_prog_rd;
      prog_addr_out <= next_prog_addr;
      table_high_we_out <= next_high_we;
      table_high_byte_reg_out <= next_high;
    end
  end

  // ==========================================
  // checks: operands presented in the previous cycle, taken or not (take_q marks a taken one)
  logic take_q;
  mst_op_t op_q;
  logic [DATA_W-1:0] byte_q;
  logic [DATA_W-1:0] acc_q;
  logic [DATA_W-1:0] imm_q;
  logic [PC_W-1:0] pc_q;
  logic [TP_W-1:0] tp_q;
  logic [ROM_W-1:0] rom_q;

  always_ff @(posedge clk_in)
  begin
    take_q <= take;
    op_q <= op_in;
    byte_q <= mem_byte_in;
    acc_q <= acc_in;
    imm_q <= imm_in;
    pc_q <= pc_in;
    tp_q <= table_pointer_in;
    rom_q <= prog_data_in;
  end

  a_swap_nibbles: assert property (@(posedge clk_in) disable iff (rst_in)
    take_q && op_q == OP_NIBBLE_SWAP_TO_ACC |-> acc_we_out && !mem_we_out
      && acc_out == {byte_q[3:0], byte_q[7:4]})
    else $error("nibble swap result wrong");

  a_byte_skip: assert property (@(posedge clk_in) disable iff (rst_in)
    take_q && op_q == OP_SKIP_IF_ZERO |-> skip_out == (byte_q == BYTE_ZERO) && !mem_we_out)
    else $error("byte zero skip wrong");

  a_skip_dummy: assert property (@(posedge clk_in) disable iff (rst_in)
    skip_out |-> !ready_out ##1 (ready_out && !skip_out))
    else $error("skip dummy cycle wrong");

  a_copy_skip: assert property (@(posedge clk_in) disable iff (rst_in)
    take_q && op_q == OP_COPY_AND_SKIP_IF_ZERO |-> acc_we_out && acc_out == byte_q
      && skip_out == (byte_q == BYTE_ZERO))
    else $error("copy and skip wrong");

  a_bit_skip: assert property (@(posedge clk_in) disable iff (rst_in)
    take_q && op_q == OP_SKIP_IF_BIT_ZERO |-> skip_out == !byte_q[$past(bit_sel_in)]
      && (skip_out || ready_out))
    else $error("bit skip timing wrong");

  a_table_current: assert property (@(posedge clk_in) disable iff (rst_in)
    take_q && op_q == OP_TABLE_READ_CURRENT_PAGE |-> prog_rd_out
      && prog_addr_out == {pc_q[PC_W-1:TP_W], tp_q} ##2 (mem_we_out && table_high_we_out))
    else $error("current page table read wrong");

  a_table_last: assert property (@(posedge clk_in) disable iff (rst_in)
    take_q && op_q == OP_TABLE_READ_LAST_PAGE |-> prog_rd_out
      && prog_addr_out == {LAST_PAGE, tp_q} ##2 (mem_we_out && ready_out))
    else $error("last page table read wrong");

  a_table_data: assert property (@(posedge clk_in) disable iff (rst_in)
    table_high_we_out |-> table_high_byte_reg_out == rom_q[ROM_W-1:DATA_W]
      && mem_wdata_out == rom_q[DATA_W-1:0])
    else $error("table word split wrong");

  a_xor_acc: assert property (@(posedge clk_in) disable iff (rst_in)
    take_q && op_q == OP_XOR_TO_ACC |-> acc_we_out && acc_out == (acc_q ^ byte_q))
    else $error("xor to acc wrong");

  a_xor_mem: assert property (@(posedge clk_in) disable iff (rst_in)
    take_q && op_q == OP_EXCLUSIVE_OR_TO_MEMORY |-> mem_we_out && zero_we_out && !acc_we_out
      && mem_wdata_out == (acc_q ^ byte_q))
    else $error("xor to memory wrong");

  a_xor_imm: assert property (@(posedge clk_in) disable iff (rst_in)
    take_q && op_q == OP_XOR_IMMEDIATE |-> acc_we_out && acc_out == (acc_q ^ imm_q)
      && zero_flag_out == ((acc_q ^ imm_q) == BYTE_ZERO))
    else $error("xor immediate wrong");

  a_flag_owner: assert property (@(posedge clk_in) disable iff (rst_in)
    zero_we_out |-> take_q && (op_q == OP_XOR_TO_ACC || op_q == OP_XOR_IMMEDIATE
      || op_q == OP_EXCLUSIVE_OR_TO_MEMORY))
    else $error("zero flag written by wrong instruction");

endmodule

// File: mst_pkg.sv
// constants, opcodes and states for the skip, table read and xor execution block
package mst_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 6;
  localparam int PC_W = 11;
  localparam int ROM_W = 14;
  localparam int TP_W = 8;
  localparam int HIGH_W = ROM_W - DATA_W;
  localparam int PAGE_W = PC_W - TP_W;

  localparam logic [PAGE_W-1:0] LAST_PAGE = 3'h7;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [HIGH_W-1:0] HIGH_RESET = 6'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 6'h00;
  localparam logic [PC_W-1:0] PROG_ADDR_RESET = 11'h000;

  // cycles from a taken instruction until the block accepts the next one
  localparam int SKIP_CYCLES = 2;
  localparam int TABLE_CYCLES = 3;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_NIBBLE_SWAP_TO_ACC,
    OP_SKIP_IF_ZERO,
    OP_COPY_AND_SKIP_IF_ZERO,
    OP_SKIP_IF_BIT_ZERO,
    OP_TABLE_READ_CURRENT_PAGE,
    OP_TABLE_READ_LAST_PAGE,
    OP_XOR_TO_ACC,
    OP_EXCLUSIVE_OR_TO_MEMORY,
    OP_XOR_IMMEDIATE
  } mst_op_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DUMMY,
    ST_TAB_ADDR,
    ST_TAB_DATA
  } mst_state_t;

endpackage

// File: mst_exec_unit.sv
// combinational datapath: results, zero test and skip decision for one instruction
`timescale 1ns/1ps
module mst_exec_unit
  import mst_pkg::*;
(
  input wire mst_op_t op_in,
  input wire logic [DATA_W-1:0] acc_in,
  input wire logic [DATA_W-1:0] mem_byte_in,
  input wire logic [DATA_W-1:0] imm_in,
  input wire logic [2:0] bit_sel_in,
  output logic acc_we_out,
  output logic [DATA_W-1:0] acc_out,
  output logic mem_we_out,
  output logic [DATA_W-1:0] mem_out,
  output logic zero_we_out,
  output logic zero_out,
  output logic skip_out,
  output logic table_out,
  output logic last_page_out
);

  // ==========================================
  // helpers
  function automatic logic is_zero(input logic [DATA_W-1:0] value);
    is_zero = (value == BYTE_ZERO);
  endfunction

  logic [DATA_W-1:0] xor_result;

  // ==========================================
  // per-instruction results
  always_comb
  begin
    xor_result = (op_in == OP_XOR_IMMEDIATE) ? (acc_in ^ imm_in) : (acc_in ^ mem_byte_in);
    acc_we_out = 1'b0;
    acc_out = acc_in;
    mem_we_out = 1'b0;
    mem_out = mem_byte_in;
    zero_we_out = 1'b0;
    zero_out = is_zero(xor_result);
    skip_out = 1'b0;
    table_out = 1'b0;
    last_page_out = 1'b0;
    case (op_in)
      OP_NIBBLE_SWAP_TO_ACC:
      begin
        acc_we_out = 1'b1;
        acc_out = {mem_byte_in[3:0], mem_byte_in[7:4]};
      end
      OP_SKIP_IF_ZERO:
      begin
        skip_out = is_zero(mem_byte_in);
      end
      OP_COPY_AND_SKIP_IF_ZERO:
      begin
        acc_we_out = 1'b1;
        acc_out = mem_byte_in;
        skip_out = is_zero(mem_byte_in);
      end
      OP_SKIP_IF_BIT_ZERO:
      begin
        skip_out = ~mem_byte_in[bit_sel_in];
      end
      OP_TABLE_READ_CURRENT_PAGE:
      begin
        table_out = 1'b1;
      end
      OP_TABLE_READ_LAST_PAGE:
      begin
        table_out = 1'b1;
        last_page_out = 1'b1;
      end
      OP_XOR_TO_ACC, OP_XOR_IMMEDIATE:
      begin
        acc_we_out = 1'b1;
        acc_out = xor_result;
        zero_we_out = 1'b1;
      end
      OP_EXCLUSIVE_OR_TO_MEMORY:
      begin
        mem_we_out = 1'b1;
        mem_out = xor_result;
        zero_we_out = 1'b1;
      end
      default:
      begin
        acc_we_out = 1'b0;
      end
    endcase
  end

endmodule

// File: mst_testbench.sv
// self-checking bench for the skip, table read and xor execution stage
`timescale 1ns/1ps
module testbench;
  import mst_pkg::*;
  // fl holds {acc_we, mem_we, zero_we, zero, skip} expected in the answer cycle
  typedef struct {
    mst_op_t op;
    logic [7:0] mem, acc, imm;
    logic [2:0] bsel;
    logic [7:0] res;
    logic [4:0] fl;
  } mst_row_t;
  // ==========================================================
  // signals and design
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic op_valid_in = 1'b0;
  mst_op_t op_in = OP_NONE;
  logic [ADDR_W-1:0] mem_addr_in = 6'h00;
  logic [DATA_W-1:0] mem_byte_in = 8'h00;
  logic [DATA_W-1:0] acc_in = 8'h00;
  logic [DATA_W-1:0] imm_in = 8'h00;
  logic [2:0] bit_sel_in = 3'h0;
  logic [PC_W-1:0] pc_in = 11'h000;
  logic [TP_W-1:0] table_pointer_in = 8'h00;
  logic [ROM_W-1:0] prog_data_in = 14'h0000;
  logic ready_out, skip_out, acc_we_out, mem_we_out, zero_we_out, zero_flag_out;
  logic prog_rd_out, table_high_we_out;
  logic [DATA_W-1:0] acc_out, mem_wdata_out;
  logic [ADDR_W-1:0] mem_addr_out;
  logic [PC_W-1:0] prog_addr_out;
  logic [HIGH_W-1:0] table_high_byte_reg_out;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  mst_row_t r;
  mst_row_t rows [16] = '{
    '{OP_NIBBLE_SWAP_TO_ACC, 8'h3c, 8'h00, 8'h00, 3'h0, 8'hc3, 5'h10},
    '{OP_SKIP_IF_ZERO, 8'h00, 8'h00, 8'h00, 3'h0, 8'h00, 5'h01},
    '{OP_SKIP_IF_ZERO, 8'h01, 8'h00, 8'h00, 3'h0, 8'h00, 5'h00},
    '{OP_COPY_AND_SKIP_IF_ZERO, 8'h00, 8'hff, 8'h00, 3'h0, 8'h00, 5'h11},
    '{OP_COPY_AND_SKIP_IF_ZERO, 8'h5a, 8'h00, 8'h00, 3'h0, 8'h5a, 5'h10},
    '{OP_SKIP_IF_BIT_ZERO, 8'hfe, 8'h00, 8'h00, 3'h0, 8'h00, 5'h01},
    '{OP_SKIP_IF_BIT_ZERO, 8'h80, 8'h00, 8'h00, 3'h7, 8'h00, 5'h00},
    '{OP_SKIP_IF_BIT_ZERO, 8'h7f, 8'h00, 8'h00, 3'h7, 8'h00, 5'h01},
    '{OP_SKIP_IF_BIT_ZERO, 8'h04, 8'h00, 8'h00, 3'h2, 8'h00, 5'h00},
    '{OP_XOR_TO_ACC, 8'h5a, 8'ha5, 8'h00, 3'h0, 8'hff, 5'h14},
    '{OP_XOR_TO_ACC, 8'h3c, 8'h3c, 8'h00, 3'h0, 8'h00, 5'h16},
    '{OP_EXCLUSIVE_OR_TO_MEMORY, 8'hf0, 8'h0f, 8'h00, 3'h0, 8'hff, 5'h0c},
    '{OP_EXCLUSIVE_OR_TO_MEMORY, 8'h55, 8'h55, 8'h00, 3'h0, 8'h00, 5'h0e},
    '{OP_XOR_IMMEDIATE, 8'hff, 8'h12, 8'h34, 3'h0, 8'h26, 5'h14},
    '{OP_XOR_IMMEDIATE, 8'h00, 8'h77, 8'h77, 3'h0, 8'h00, 5'h16},
    '{OP_NONE, 8'h00, 8'h00, 8'h00, 3'h0, 8'h00, 5'h00}
  };
  always #5 clk_in = ~clk_in;
  mst_skip_table_xor u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .op_valid_in(op_valid_in), .op_in(op_in),
    .mem_addr_in(mem_addr_in), .mem_byte_in(mem_byte_in), .acc_in(acc_in),
    .imm_in(imm_in), .bit_sel_in(bit_sel_in), .pc_in(pc_in),
    .table_pointer_in(table_pointer_in), .prog_data_in(prog_data_in),
    .ready_out(ready_out), .skip_out(skip_out), .acc_we_out(acc_we_out),
    .acc_out(acc_out), .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out),
    .mem_wdata_out(mem_wdata_out), .zero_we_out(zero_we_out),
    .zero_flag_out(zero_flag_out), .prog_rd_out(prog_rd_out),
    .prog_addr_out(prog_addr_out), .table_high_we_out(table_high_we_out),
    .table_high_byte_reg_out(table_high_byte_reg_out)
  );
  // ==========================================================
  // tasks
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic step();
    @(posedge clk_in);
    #1;
  endtask
  task automatic issue(input mst_op_t op, input logic [7:0] m, a, x,
                       input logic [2:0] b, input logic [5:0] ad);
    op_valid_in = 1'b1;
    op_in = op;
    mem_byte_in = m;
    acc_in = a;
    imm_in = x;
    bit_sel_in = b;
    mem_addr_in = ad;
    step();
  endtask
  // hang guard, far above the length of the sequence
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 1000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (8) @(posedge clk_in);
    #1;
    check(16'({ready_out, skip_out, acc_we_out, mem_we_out, prog_rd_out}), 16'h0010);
    rst_in = 1'b0;
    $display("test reset done");
    for (int i = 0; i < 16; i++)
    begin
      r = rows[i];
      issue(r.op, r.mem, r.acc, r.imm, r.bsel, 6'(i));
      check(16'(acc_we_out), 16'(r.fl[4]));
      check(16'(mem_we_out), 16'(r.fl[3]));
      check(16'(zero_we_out), 16'(r.fl[2]));
      check(16'(skip_out), 16'(r.fl[0]));
      check(16'(ready_out), 16'(!r.fl[0]));
      check(16'({prog_rd_out, table_high_we_out}), 16'h0000);
      check(16'(mem_addr_out), 16'(i));
      if (r.fl[4])
        check(16'(acc_out), 16'(r.res));
      if (r.fl[3])
        check(16'(mem_wdata_out), 16'(r.res));
      if (r.fl[2])
        check(16'(zero_flag_out), 16'(r.fl[1]));
      if (r.fl[0])
      begin
        op_valid_in = 1'b0;
        step();
        check(16'({skip_out, ready_out}), 16'h0001);
      end
    end
    $display("test table rows done");
    // request during the dummy cycle is held off until ready returns
    issue(OP_SKIP_IF_ZERO, 8'h00, 8'h00, 8'h00, 3'h0, 6'h01);
    op_in = OP_XOR_IMMEDIATE;
    acc_in = 8'h01;
    imm_in = 8'h02;
    step();
    check(16'({acc_we_out, ready_out}), 16'h0001);
    step();
    check(16'({acc_we_out, acc_out}), 16'h0103);
    $display("test refused during dummy done");
    for (int k = 0; k < 2; k++)
    begin
      pc_in = 11'h5a3;
      table_pointer_in = 8'h4c + 8'(k);
      issue(k ? OP_TABLE_READ_LAST_PAGE : OP_TABLE_READ_CURRENT_PAGE,
            8'h00, 8'h00, 8'h00, 3'h0, 6'h2a);
      op_valid_in = 1'b0;
      check(16'({prog_rd_out, ready_out}), 16'h0002);
      check(16'(prog_addr_out), 16'({k ? 3'h7 : 3'h5, table_pointer_in}));
      step();
      prog_data_in = 14'h2b7e ^ 14'(k);
      check(16'({prog_rd_out, ready_out}), 16'h0000);
      step();
      prog_data_in = ~prog_data_in;
      check(16'({mem_we_out, table_high_we_out, ready_out}), 16'h0007);
      check(16'(mem_wdata_out), 16'(8'h7e ^ 8'(k)));
      check(16'(table_high_byte_reg_out), 16'h002b);
      check(16'({mem_addr_out, zero_we_out, acc_we_out}), 16'h00a8);
    end
    $display("test table read done");
    issue(OP_SKIP_IF_ZERO, 8'h00, 8'h00, 8'h00, 3'h0, 6'h05);
    op_valid_in = 1'b0;
    rst_in = 1'b1;
    #1;
    check(16'({ready_out, skip_out, acc_out, table_high_byte_reg_out}), 16'h8000);
    step();
    rst_in = 1'b0;
    issue(OP_XOR_TO_ACC, 8'hf0, 8'h0f, 8'h00, 3'h0, 6'h00);
    op_valid_in = 1'b0;
    check(16'({acc_we_out, acc_out}), 16'h01ff);
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule
